// ### txls_pkg.sv
// Purpose: shared constants and carrier types for the tx lane status bank
// Assumes: 32-bit APB data, 12-bit byte address, up to eight lanes
// Notes: offsets are byte addresses, one aligned word per register
package txls_pkg;

  localparam int TXLS_LANES = 8;
  localparam int TXLS_AW = 12;
  localparam int TXLS_DW = 32;
  localparam int TXLS_SYNC_STAGES = 2;

  // register byte offsets
  localparam logic [11:0] TXLS_FIFO_FLAGS_OFS = 12'h084;
  localparam logic [11:0] TXLS_PLL_CAL_OFS = 12'h088;
  localparam logic [11:0] TXLS_CTRL_OFS = 12'h0a0;

  // field positions inside the status and control words
  localparam int TXLS_HI_LSB = 16;
  localparam int TXLS_LO_LSB = 0;
  localparam int TXLS_CTRL_BONDED_BIT = 0;
  localparam int TXLS_CTRL_FREEZE_BIT = 1;

  // reset values and the all-ones lane byte
  localparam logic [31:0] TXLS_STAT_RST = 32'h0000_0000;
  localparam logic [7:0] TXLS_LANE_RST = 8'h00;
  localparam logic [7:0] TXLS_LANE_ONES = 8'hff;
  localparam logic TXLS_BONDED_RST = 1'b0;
  localparam logic TXLS_FREEZE_RST = 1'b0;

  // raw per-lane state and the shared pll lock arriving from the transceiver side
  typedef struct packed {
    logic [TXLS_LANES-1:0] fifo_empty;
    logic [TXLS_LANES-1:0] fifo_full;
    logic [TXLS_LANES-1:0] pll_lock;
    logic [TXLS_LANES-1:0] cal_busy;
    logic shared_pll_lock;
  } txls_lane_in_t;

  typedef struct packed {
    logic freeze;
    logic bonded;
  } txls_ctrl_t;

  // two lane fields into one status word; bits 31:24 and 15:8 stay zero
  function automatic logic [31:0] txls_place(input logic [7:0] hi, input logic [7:0] lo);
    logic [31:0] w;
    w = TXLS_STAT_RST;
    w[TXLS_HI_LSB +: 8] = hi;
    w[TXLS_LO_LSB +: 8] = lo;
    return w;
  endfunction

endpackage

// ### txls_sync.sv
// Purpose: two-flop synchroniser for a vector of independent levels
// Assumes: each bit is a slow level; no bus coherency across bits
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module txls_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// ### txls_regs.sv
// Purpose: read-only tx lane status bank on APB, plus a small control word
// Assumes: transceiver status is asynchronous to pclk; APB master is well behaved
// Notes: zero wait states; status lags the lane signals by three pclk edges
//
// Overview of operation
// - bits 23:16 show per-lane fifo empty
// - bits 7:0 show per-lane fifo full
// - fifo flags at 0x84, zero after reset
// - bits 23:16 of second word show lock
// - bonded mode: shared lock on lane 0 only
// - non-bonded mode: each lane its own lock
// - variant without lock reporting reads all ones
// - second word low byte shows calibration busy
// - calibration bits meaningless on variant without reporting
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module txls_regs
  import txls_pkg::*;
#(
  parameter int NUM_LANES = txls_pkg::TXLS_LANES,
  parameter bit NO_LANE_LOCK = 1'b0,
  parameter bit NO_CAL_REPORT = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [txls_pkg::TXLS_AW-1:0] paddr,
  input wire logic [txls_pkg::TXLS_DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [txls_pkg::TXLS_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire txls_pkg::txls_lane_in_t lane_in
);
  import txls_pkg::*;

  // lanes above NUM_LANES are not built and read as zero, except in the lock byte of the NO_LANE_LOCK variant, which reads all ones
  localparam logic [7:0] LANE_MASK = 8'(TXLS_LANE_ONES >> (TXLS_LANES - NUM_LANES));

  txls_lane_in_t lane_sync;
  txls_ctrl_t ctrl;
  logic [7:0] fifo_empty_stat;
  logic [7:0] fifo_full_stat;
  logic [7:0] pll_lock_stat;
  logic [7:0] cal_stat;

  // every lane signal crosses in through two flops first
  txls_sync #(
    .W($bits(txls_lane_in_t))
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(lane_in),
    .q(lane_sync)
  );

  // lock view depends on variant and on bonding
  wire [7:0] lock_bonded = {7'h00, lane_sync.shared_pll_lock};
  wire [7:0] lock_per_lane = lane_sync.pll_lock;
  wire [7:0] lock_view = NO_LANE_LOCK ? TXLS_LANE_ONES
                       : (ctrl.bonded ? lock_bonded : lock_per_lane) & LANE_MASK;
  // calibration bits carry nothing on that variant; zero keeps them stable
  wire [7:0] cal_view = NO_CAL_REPORT ? TXLS_LANE_RST
                      : lane_sync.cal_busy & LANE_MASK;
  wire [7:0] empty_view = lane_sync.fifo_empty & LANE_MASK;
  wire [7:0] full_view = lane_sync.fifo_full & LANE_MASK;

  // freeze holds a coherent snapshot while software reads both words
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fifo_empty_stat <= TXLS_LANE_RST;
      fifo_full_stat <= TXLS_LANE_RST;
      pll_lock_stat <= TXLS_LANE_RST;
      cal_stat <= TXLS_LANE_RST;
    end
    else if (!ctrl.freeze)
    begin
      fifo_empty_stat <= empty_view;
      fifo_full_stat <= full_view;
      pll_lock_stat <= lock_view;
      cal_stat <= cal_view;
    end
  end

  // bus decode
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire aligned = (paddr[1:0] == 2'b00);
  wire hit_fifo = aligned && (paddr == TXLS_FIFO_FLAGS_OFS);
  wire hit_pll = aligned && (paddr == TXLS_PLL_CAL_OFS);
  wire hit_ctrl = aligned && (paddr == TXLS_CTRL_OFS);
  wire hit_any = hit_fifo || hit_pll || hit_ctrl;

  wire [31:0] fifo_word = txls_place(fifo_empty_stat, fifo_full_stat);
  wire [31:0] pll_word = txls_place(pll_lock_stat, cal_stat);
  wire [31:0] ctrl_word = {30'h0, ctrl.freeze, ctrl.bonded};
  wire [31:0] rd_word = hit_fifo ? fifo_word
                      : hit_pll ? pll_word
                      : hit_ctrl ? ctrl_word
                      : TXLS_STAT_RST;

  // only the control word takes writes; status words drop them silently
  wire ctrl_we = access && pwrite && hit_ctrl && pstrb[0];

  assign pready = 1'b1;
  assign pslverr = access && !hit_any;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl.bonded <= TXLS_BONDED_RST;
      ctrl.freeze <= TXLS_FREEZE_RST;
    end
    else if (ctrl_we)
    begin
      ctrl.bonded <= pwdata[TXLS_CTRL_BONDED_BIT];
      ctrl.freeze <= pwdata[TXLS_CTRL_FREEZE_BIT];
    end
  end

  // read data is caught at setup so it comes from a flop in the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= TXLS_STAT_RST;
    end
    else if (setup && !pwrite)
    begin
      prdata <= rd_word;
    end
  end

  property p_empty_read;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit_fifo)
    |=> (prdata[23:16] == $past(fifo_empty_stat));
  endproperty
  a_empty_read: assert property (p_empty_read)
    else $error("empty flags not at bits 23:16");

  property p_full_read;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit_fifo)
    |=> (prdata[7:0] == $past(fifo_full_stat)) && pready && !pslverr;
  endproperty
  a_full_read: assert property (p_full_read)
    else $error("full flags not at bits 7:0");

  property p_empty_tracks;
    @(posedge pclk) disable iff (!presetn)
    !ctrl.freeze
    |=> (fifo_empty_stat == $past(lane_sync.fifo_empty & LANE_MASK));
  endproperty
  a_empty_tracks: assert property (p_empty_tracks)
    else $error("empty status does not follow the lane");

  property p_stat_reset;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (fifo_empty_stat == TXLS_LANE_RST)
                       && (fifo_full_stat == TXLS_LANE_RST) && (prdata == TXLS_STAT_RST);
  endproperty
  a_stat_reset: assert property (p_stat_reset)
    else $error("status not zero after reset");

  property p_lock_nonbonded;
    @(posedge pclk) disable iff (!presetn)
    (!NO_LANE_LOCK && !ctrl.bonded && !ctrl.freeze)
    |=> (pll_lock_stat == $past(lane_sync.pll_lock & LANE_MASK));
  endproperty
  a_lock_nonbonded: assert property (p_lock_nonbonded)
    else $error("per-lane lock not routed");

  property p_lock_bonded;
    @(posedge pclk) disable iff (!presetn)
    (!NO_LANE_LOCK && ctrl.bonded && !ctrl.freeze)
    |=> (pll_lock_stat[7:1] == 7'h00)
        && (pll_lock_stat[0] == $past(lane_sync.shared_pll_lock));
  endproperty
  a_lock_bonded: assert property (p_lock_bonded)
    else $error("bonded lock not on lane 0 alone");

  property p_lock_read;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit_pll) |=> (prdata[23:16] == $past(pll_lock_stat));
  endproperty
  a_lock_read: assert property (p_lock_read)
    else $error("lock bits not at 23:16");

  property p_lock_tied;
    @(posedge pclk) disable iff (!presetn)
    (NO_LANE_LOCK && !ctrl.freeze) |=> (pll_lock_stat == TXLS_LANE_ONES);
  endproperty
  a_lock_tied: assert property (p_lock_tied)
    else $error("lock bits not tied to one");

  property p_cal_read;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit_pll && !ctrl.freeze && !$past(ctrl.freeze) && !NO_CAL_REPORT)
    |=> (prdata[7:0] == ($past(lane_sync.cal_busy, 2) & LANE_MASK));
  endproperty
  a_cal_read: assert property (p_cal_read)
    else $error("calibration bits not in low byte");

  property p_cal_absent;
    @(posedge pclk) disable iff (!presetn)
    NO_CAL_REPORT |-> (cal_stat == TXLS_LANE_RST);
  endproperty
  a_cal_absent: assert property (p_cal_absent)
    else $error("calibration bits move on variant without them");

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && (hit_fifo || hit_pll))
    |=> (prdata[31:24] == 8'h00) && (prdata[15:8] == 8'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits not zero");

  property p_status_write_ignored;
    @(posedge pclk) disable iff (!presetn)
    (access && pwrite && (hit_fifo || hit_pll)) |=> $stable(ctrl) && !$past(pslverr);
  endproperty
  a_status_write_ignored: assert property (p_status_write_ignored)
    else $error("write to status word had an effect");

  property p_ctrl_write;
    @(posedge pclk) disable iff (!presetn)
    ctrl_we |=> (ctrl.bonded == $past(pwdata[0])) && (ctrl.freeze == $past(pwdata[1]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write lost");

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
    (setup && !hit_any) |=> pslverr && pready;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped address not flagged");

  property p_full_tracks;
    @(posedge pclk) disable iff (!presetn)
    !ctrl.freeze
    |=> (fifo_full_stat == $past(lane_sync.fifo_full & LANE_MASK));
  endproperty
  a_full_tracks: assert property (p_full_tracks)
    else $error("full status does not follow the lane");

  property p_cal_tracks;
    @(posedge pclk) disable iff (!presetn)
    (!NO_CAL_REPORT && !ctrl.freeze)
    |=> (cal_stat == $past(lane_sync.cal_busy & LANE_MASK));
  endproperty
  a_cal_tracks: assert property (p_cal_tracks)
    else $error("calibration status does not follow the lane");

  // software relies on this to read both words from one instant
  property p_freeze_hold;
    @(posedge pclk) disable iff (!presetn)
    ctrl.freeze
    |=> $stable(fifo_empty_stat) && $stable(fifo_full_stat)
        && $stable(pll_lock_stat) && $stable(cal_stat);
  endproperty
  a_freeze_hold: assert property (p_freeze_hold)
    else $error("status moved while frozen");

  property p_unbuilt_lanes;
    @(posedge pclk) disable iff (!presetn)
    ((fifo_empty_stat | fifo_full_stat | cal_stat) & ~LANE_MASK) == 8'h00;
  endproperty
  a_unbuilt_lanes: assert property (p_unbuilt_lanes)
    else $error("lane that is not built shows a flag");

  property p_fifo_word;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit_fifo)
    |=> (prdata == {8'h00, $past(fifo_empty_stat), 8'h00, $past(fifo_full_stat)});
  endproperty
  a_fifo_word: assert property (p_fifo_word)
    else $error("fifo flag word wrong");

  property p_pll_word;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit_pll)
    |=> (prdata == {8'h00, $past(pll_lock_stat), 8'h00, $past(cal_stat)});
  endproperty
  a_pll_word: assert property (p_pll_word)
    else $error("lock and calibration word wrong");

  // the status flop lags one edge, so the bonding that loaded it is the past one
  property p_bonded_read;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit_pll && !NO_LANE_LOCK && $past(ctrl.bonded) && !$past(ctrl.freeze))
    |=> (prdata[23:17] == 7'h00);
  endproperty
  a_bonded_read: assert property (p_bonded_read)
    else $error("bonded read shows lock above lane 0");

  property p_ctrl_readback;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit_ctrl)
    |=> (prdata == {30'h0, $past(ctrl.freeze), $past(ctrl.bonded)});
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback)
    else $error("control word read back wrong");

  property p_unmapped_data;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && !hit_any)
    |=> (prdata == TXLS_STAT_RST);
  endproperty
  a_unmapped_data: assert property (p_unmapped_data)
    else $error("unmapped read returned data");

  property p_prdata_hold;
    @(posedge pclk) disable iff (!presetn)
    !(setup && !pwrite)
    |=> $stable(prdata);
  endproperty
  a_prdata_hold: assert property (p_prdata_hold)
    else $error("read data moved outside a read setup");

  property p_ctrl_hold;
    @(posedge pclk) disable iff (!presetn)
    !ctrl_we
    |=> $stable(ctrl);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("control changed without a write");

  property p_status_no_err;
    @(posedge pclk) disable iff (!presetn)
    (setup && (hit_fifo || hit_pll))
    |=> !pslverr && pready;
  endproperty
  a_status_no_err: assert property (p_status_no_err)
    else $error("status word access flagged an error");

  property p_lock_cal_reset;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (pll_lock_stat == TXLS_LANE_RST) && (cal_stat == TXLS_LANE_RST)
                       && !ctrl.bonded && !ctrl.freeze;
  endproperty
  a_lock_cal_reset: assert property (p_lock_cal_reset)
    else $error("lock, calibration or control not zero after reset");

endmodule

// ### tx_lane_status_regs_tb_top.sv
// Purpose: self-checking bench for the tx lane status bank over apb
// Assumes: zero wait state slave, lane levels visible three edges after a change
// Notes: a second, four-lane instance without lock or calibration reporting shares the bus
`timescale 1ns/1ps
module tx_lane_status_regs_tb_top;
  import txls_pkg::*;
  `define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pready_nl, pslverr_nl, err, err_nl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, prdata_nl, rd, rd_nl;
  logic [3:0] pstrb;
  txls_lane_in_t lane_in;
  int errors, compares;
  txls_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lane_in(lane_in));
  txls_regs #(.NUM_LANES(4), .NO_LANE_LOCK(1'b1), .NO_CAL_REPORT(1'b1)) dut_nolock (
    .pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata_nl), .pready(pready_nl), .pslverr(pslverr_nl), .lane_in(lane_in));
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task summarize;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // request is held until pready and pready_nl are both seen high at a rising edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while ((pready !== 1'b1 || pready_nl !== 1'b1) && n < 16);
    if (pready !== 1'b1 || pready_nl !== 1'b1)
    begin
      errors++;
      summarize();
    end
    rd = prdata;
    rd_nl = prdata_nl;
    err = pslverr;
    err_nl = pslverr_nl;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // three edges of sync and status flop pass before the next setup
  task set_lanes(input logic [7:0] e, f, l, c, input logic s);
    @(posedge pclk);
    lane_in <= {e, f, l, c, s};
    repeat (3) @(posedge pclk);
  endtask
  task expect_status(input logic [7:0] e, f, l, c);
    xfer(1'b0, TXLS_FIFO_FLAGS_OFS, 32'h0);
    `CHK("fifo_flags", {8'h00, e, 8'h00, f}, rd)
    `CHK("fifo_flags_err", 1'b0, err)
    `CHK("nl_flags", {8'h00, e & 8'h0f, 8'h00, f & 8'h0f}, rd_nl)
    xfer(1'b0, TXLS_PLL_CAL_OFS, 32'h0);
    `CHK("pll_cal", {8'h00, l, 8'h00, c}, rd)
    `CHK("nolock_lock", 32'h00ff_0000, rd_nl)
  endtask
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    lane_in = '1;
    errors = 0;
    compares = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // first read right after release: lanes are all ones but must not show yet
    xfer(1'b0, TXLS_FIFO_FLAGS_OFS, 32'h0);
    `CHK("reset_flags", 32'h0000_0000, rd)
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      set_lanes(8'h01 << i, 8'h80 >> i, 8'h01 << i, 8'h80 >> i, 1'b1);
      expect_status(8'h01 << i, 8'h80 >> i, 8'h01 << i, 8'h80 >> i);
    end
    set_lanes(8'ha5, 8'h3c, 8'h96, 8'he1, 1'b0);
    expect_status(8'ha5, 8'h3c, 8'h96, 8'he1);
    $display("test lane walk done");
    xfer(1'b1, TXLS_CTRL_OFS, 32'h0000_0001);
    xfer(1'b0, TXLS_CTRL_OFS, 32'h0);
    `CHK("ctrl", 32'h0000_0001, rd)
    set_lanes(8'h00, 8'h00, 8'hfe, 8'h00, 1'b1);
    expect_status(8'h00, 8'h00, 8'h01, 8'h00);
    set_lanes(8'h00, 8'h00, 8'hff, 8'h00, 1'b0);
    expect_status(8'h00, 8'h00, 8'h00, 8'h00);
    xfer(1'b1, TXLS_CTRL_OFS, 32'h0);
    $display("test bonded done");
    pstrb <= 4'he;
    xfer(1'b1, TXLS_CTRL_OFS, 32'h0000_0001);
    pstrb <= 4'hf;
    xfer(1'b0, TXLS_CTRL_OFS, 32'h0);
    `CHK("ctrl_nostrb", 32'h0000_0000, rd)
    set_lanes(8'h11, 8'h22, 8'h33, 8'h44, 1'b0);
    xfer(1'b1, TXLS_CTRL_OFS, 32'h0000_0002);
    set_lanes(8'hee, 8'hdd, 8'hcc, 8'hbb, 1'b0);
    expect_status(8'h11, 8'h22, 8'h33, 8'h44);
    xfer(1'b1, TXLS_CTRL_OFS, 32'h0);
    expect_status(8'hee, 8'hdd, 8'hcc, 8'hbb);
    $display("test freeze done");
    // status words are live levels, so a write must leave them unchanged
    set_lanes(8'h5a, 8'hc3, 8'h0f, 8'h99, 1'b1);
    xfer(1'b1, TXLS_FIFO_FLAGS_OFS, 32'hffff_ffff);
    `CHK("wr_flags_err", 1'b0, err)
    xfer(1'b1, TXLS_PLL_CAL_OFS, 32'hffff_ffff);
    `CHK("wr_pllcal_err", 1'b0, err)
    expect_status(8'h5a, 8'hc3, 8'h0f, 8'h99);
    $display("test write ignored done");
    xfer(1'b0, 12'h090, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_err_nl", 1'b1, err_nl)
    `CHK("unmapped_data", 32'h0000_0000, rd)
    xfer(1'b0, 12'h086, 32'h0);
    `CHK("unaligned_err", 1'b1, err)
    expect_status(8'h5a, 8'hc3, 8'h0f, 8'h99);
    $display("test unmapped done");
    xfer(1'b1, TXLS_CTRL_OFS, 32'h0000_0003);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, TXLS_FIFO_FLAGS_OFS, 32'h0);
    `CHK("rereset_flags", 32'h0000_0000, rd)
    xfer(1'b0, TXLS_CTRL_OFS, 32'h0);
    `CHK("rereset_ctrl", 32'h0000_0000, rd)
    $display("test second reset done");
    summarize();
  end
endmodule
